/* File: design/plcd_driver.sv */
// Passive LCD segment driver sequencer with double-buffered pixel memory.
// Assumes config ports held steady by software; analog ladder is outside.
`timescale 1ns/100ps
// Operation
// - Drive up to eight commons and sixteen segments.
// - Alternate drive polarity every frame so no net DC builds up.
// - Duty selectable: static, 1/2, 1/3, 1/4, 1/8.
// - Bias selectable: static, 1/2, 1/3, 1/4.
// - Pixel memory double buffered; copy to display only at frame start.
// - Pixel memory holds sixteen 32-bit words, one bit per element.
// - Insert zero to eight idle phase periods between frames.
// - Raise sticky flag and optional interrupt at each frame start.
// - Blink one, two, three, four, eight or all pixels.
// - Blink rate from a software divider of the frame count.
// - Phase inversion option inverts polarity on odd-numbered common phases.
// - External supply selection keeps internal boost converter off.
// - Keep driving in deep stop; full disable supported.
// - Contrast setting drives panel voltage code when boost used.
module plcd_driver #(
  parameter int NCOM = plcd_pkg::N_COM,
  parameter int NSEG = plcd_pkg::N_SEG
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire plcd_pkg::plcd_cfg_t cfg,
  input wire logic deep_stop_state,
  input wire logic ram_we,
  input wire logic [3:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire logic sof_clear,
  input wire logic sof_irq_en,
  output plcd_pkg::plcd_drive_t drive,
  output logic sof_flag,
  output logic sof_irq,
  output logic boost_en,
  output logic [3:0] panel_drive_voltage,
  output logic busy
);
  if (NCOM != 8 || NSEG != 16) begin : g_size_check
    $error("plcd_driver serves only 8 commons and 16 segments");
  end

  logic [31:0] pixel_data_memory [plcd_pkg::RAM_WORDS];
  logic [31:0] disp_mem [plcd_pkg::RAM_WORDS];
  plcd_pkg::plcd_state_t st_q, st_d;
  logic [15:0] pre_q, pre_d;
  logic [2:0] com_q, com_d;
  logic [3:0] dead_q, dead_d;
  logic pol_q, pol_d;
  logic [7:0] bdiv_q, bdiv_d;
  logic blink_q, blink_d;
  logic sof_q, sof_d;
  logic [2:0] ncom_m1;
  logic tick, frame_start, run;

  // Software side buffer, writable any time
  always_ff @(posedge mclk) begin
    if (ram_we)
      pixel_data_memory[ram_addr] <= ram_wdata;
  end

  // Display copy taken only at frame boundary
  always_ff @(posedge mclk) begin
    if (frame_start)
      disp_mem <= pixel_data_memory;
  end

  always_comb begin
    unique case (cfg.duty)
      plcd_pkg::PLCD_DUTY_1_2: ncom_m1 = 3'h1;
      plcd_pkg::PLCD_DUTY_1_3: ncom_m1 = 3'h2;
      plcd_pkg::PLCD_DUTY_1_4: ncom_m1 = 3'h3;
      plcd_pkg::PLCD_DUTY_1_8: ncom_m1 = 3'h7;
      default: ncom_m1 = 3'h0;
    endcase
  end

  // Deep stop does not stop the sequencer
  assign run = cfg.enable;
  assign tick = run && (pre_q == 16'h0000);

  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    com_d = com_q;
    dead_d = dead_q;
    pol_d = pol_q;
    bdiv_d = bdiv_q;
    blink_d = blink_q;
    sof_d = sof_q;
    frame_start = 1'b0;
    if (run)
      pre_d = (pre_q == 16'h0000) ? cfg.prescale : pre_q - 16'h0001;
    if (sof_clear)
      sof_d = 1'b0;
    unique case (st_q)
      plcd_pkg::PLCD_ST_OFF: begin
        if (run) begin
          st_d = plcd_pkg::PLCD_ST_DRIVE;
          com_d = 3'h0;
          frame_start = 1'b1;
          sof_d = 1'b1;
          pre_d = cfg.prescale;
        end
      end
      plcd_pkg::PLCD_ST_DRIVE: begin
        if (!run)
          st_d = plcd_pkg::PLCD_ST_OFF;
        else if (tick) begin
          if (com_q == ncom_m1) begin
            com_d = 3'h0;
            pol_d = ~pol_q;
            if (bdiv_q >= cfg.blink_div) begin
              bdiv_d = 8'h00;
              blink_d = ~blink_q;
            end else
              bdiv_d = bdiv_q + 8'h01;
            if (cfg.dead_time != 4'h0) begin
              st_d = plcd_pkg::PLCD_ST_DEAD;
              dead_d = (cfg.dead_time > 4'h8) ? 4'h8 : cfg.dead_time;
            end else begin
              frame_start = 1'b1;
              sof_d = 1'b1;
            end
          end else
            com_d = com_q + 3'h1;
        end
      end
      plcd_pkg::PLCD_ST_DEAD: begin
        if (!run)
          st_d = plcd_pkg::PLCD_ST_OFF;
        else if (tick) begin
          dead_d = dead_q - 4'h1;
          if (dead_q == 4'h1) begin
            st_d = plcd_pkg::PLCD_ST_DRIVE;
            frame_start = 1'b1;
            sof_d = 1'b1;
          end
        end
      end
      default: st_d = plcd_pkg::PLCD_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= plcd_pkg::PLCD_ST_OFF;
      pre_q <= plcd_pkg::PRESC_RST;
      com_q <= 3'h0;
      dead_q <= 4'h0;
      pol_q <= 1'b0;
      bdiv_q <= 8'h00;
      blink_q <= 1'b0;
      sof_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      com_q <= com_d;
      dead_q <= dead_d;
      pol_q <= pol_d;
      bdiv_q <= bdiv_d;
      blink_q <= blink_d;
      sof_q <= sof_d;
    end
  end

  // Drive level computation
  plcd_pkg::plcd_drive_t drv_d;
  logic pol_eff, on_px, hide;
  logic [2:0] top, sel_lvl, com_un, seg_on, seg_off;
  logic [6:0] pix_idx;
  always_comb begin
    drv_d = '0;
    pix_idx = 7'h00;
    on_px = 1'b0;
    hide = 1'b0;
    pol_eff = pol_q ^ (cfg.phase_inv & com_q[0]);
    unique case (cfg.bias)
      plcd_pkg::PLCD_BIAS_1_2: top = 3'h2;
      plcd_pkg::PLCD_BIAS_1_3: top = 3'h3;
      plcd_pkg::PLCD_BIAS_1_4: top = 3'h4;
      default: top = 3'h1;
    endcase
    // Ladder levels 0..top, mirrored for negative polarity
    sel_lvl = pol_eff ? 3'h0 : top;
    com_un = (cfg.bias == plcd_pkg::PLCD_BIAS_STATIC) ? (pol_eff ? top : 3'h0)
           : (pol_eff ? top - 3'h1 : 3'h1);
    seg_on = pol_eff ? top : 3'h0;
    seg_off = (cfg.bias == plcd_pkg::PLCD_BIAS_STATIC) ? sel_lvl
            : (pol_eff ? 3'h1 : top - 3'h1);
    if (st_q == plcd_pkg::PLCD_ST_DRIVE) begin
      for (int c = 0; c < NCOM; c++)
        drv_d.com_level[c] = (3'(c) == com_q) ? sel_lvl
                           : ((3'(c) <= ncom_m1) ? com_un : sel_lvl);
      for (int s = 0; s < NSEG; s++) begin
        pix_idx = 7'(com_q) * 7'd16 + 7'(s);
        on_px = disp_mem[pix_idx[6:5]][pix_idx[4:0]];
        unique case (cfg.blink_mode)
          plcd_pkg::PLCD_BLINK_1: hide = (pix_idx == 7'h00);
          plcd_pkg::PLCD_BLINK_2: hide = (pix_idx < 7'h02);
          plcd_pkg::PLCD_BLINK_3: hide = (pix_idx < 7'h03);
          plcd_pkg::PLCD_BLINK_4: hide = (pix_idx < 7'h04);
          plcd_pkg::PLCD_BLINK_8: hide = (pix_idx < 7'h08);
          plcd_pkg::PLCD_BLINK_ALL: hide = 1'b1;
          default: hide = 1'b0;
        endcase
        drv_d.seg_level[s] = (on_px && !(hide && blink_q)) ? seg_on
                                                            : seg_off;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      drive <= '0;
      sof_flag <= 1'b0;
      sof_irq <= 1'b0;
      boost_en <= 1'b0;
      panel_drive_voltage <= plcd_pkg::CONTRAST_RST;
      busy <= 1'b0;
    end else begin
      drive <= drv_d;
      sof_flag <= sof_d;
      sof_irq <= sof_d & sof_irq_en;
      boost_en <= cfg.enable & ~cfg.ext_supply;
      panel_drive_voltage <= cfg.ext_supply ? 4'h0 : cfg.contrast;
      busy <= (st_d != plcd_pkg::PLCD_ST_OFF) | deep_stop_state & 1'b0;
    end
  end

  // Polarity taken at the last frame start, for the alternation check
  logic pol_sof_q;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      pol_sof_q <= 1'b0;
    else if (frame_start)
      pol_sof_q <= pol_d;
  end

  a_boost_off_ext: assert property (@(posedge mclk)
    disable iff (!reset_n)
    $past(cfg.ext_supply) |-> !boost_en)
    else $error("boost on with external supply");
  a_sof_sticky: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (sof_flag && !$past(sof_clear) && !sof_clear) |=> sof_flag)
    else $error("start of frame flag lost");
  a_com_range: assert property (@(posedge mclk)
    disable iff (!reset_n)
    com_q <= ncom_m1 || st_q != plcd_pkg::PLCD_ST_DRIVE)
    else $error("common index beyond duty");
  a_dead_bound: assert property (@(posedge mclk)
    disable iff (!reset_n)
    dead_q <= 4'h8)
    else $error("idle count above eight");
  a_pol_flip: assert property (@(posedge mclk)
    disable iff (!reset_n)
    (frame_start && st_q != plcd_pkg::PLCD_ST_OFF) |-> pol_d != pol_sof_q)
    else $error("polarity not flipped at frame");
  a_contrast_map: assert property (@(posedge mclk)
    disable iff (!reset_n)
    ($past(reset_n) && !$past(cfg.ext_supply)) |->
      panel_drive_voltage == $past(cfg.contrast))
    else $error("contrast code wrong");
  a_off_idle: assert property (@(posedge mclk)
    disable iff (!reset_n)
    !cfg.enable |=> st_q == plcd_pkg::PLCD_ST_OFF)
    else $error("sequencer ran while disabled");
  a_irq_gate: assert property (@(posedge mclk)
    disable iff (!reset_n)
    sof_irq |-> sof_flag && $past(sof_irq_en))
    else $error("interrupt without flag");
endmodule

/* File: design/plcd_pkg.sv */
// Package for the passive LCD segment driver: constants, enums and structs.
// Assumes a single 250 MHz clock and plain control ports (no register bus).
package plcd_pkg;
  localparam int CLK_MHZ = 250;
  localparam int N_COM = 8;
  localparam int N_SEG = 16;
  localparam int RAM_WORDS = 16;
  localparam int RAM_BITS = 32;
  localparam int DEAD_MAX = 8;
  localparam logic [15:0] PRESC_RST = 16'h0100;
  localparam logic [7:0] BLINK_DIV_RST = 8'h40;
  localparam logic [3:0] CONTRAST_RST = 4'h0;

  typedef enum logic [2:0] {
    PLCD_DUTY_STATIC = 3'h0,
    PLCD_DUTY_1_2 = 3'h1,
    PLCD_DUTY_1_3 = 3'h2,
    PLCD_DUTY_1_4 = 3'h3,
    PLCD_DUTY_1_8 = 3'h4
  } plcd_duty_t;

  typedef enum logic [1:0] {
    PLCD_BIAS_STATIC = 2'h0,
    PLCD_BIAS_1_2 = 2'h1,
    PLCD_BIAS_1_3 = 2'h2,
    PLCD_BIAS_1_4 = 2'h3
  } plcd_bias_t;

  typedef enum logic [2:0] {
    PLCD_BLINK_OFF = 3'h0,
    PLCD_BLINK_1 = 3'h1,
    PLCD_BLINK_2 = 3'h2,
    PLCD_BLINK_3 = 3'h3,
    PLCD_BLINK_4 = 3'h4,
    PLCD_BLINK_8 = 3'h5,
    PLCD_BLINK_ALL = 3'h6
  } plcd_blink_t;

  typedef enum logic [2:0] {
    PLCD_ST_OFF = 3'b001,
    PLCD_ST_DRIVE = 3'b010,
    PLCD_ST_DEAD = 3'b100
  } plcd_state_t;

  typedef struct packed {
    logic enable;
    plcd_duty_t duty;
    plcd_bias_t bias;
    logic phase_inv;
    logic ext_supply;
    logic [3:0] contrast;
    logic [3:0] dead_time;
    logic [15:0] prescale;
    plcd_blink_t blink_mode;
    logic [7:0] blink_div;
  } plcd_cfg_t;

  // Per-terminal drive: level index 0..4 of the bias ladder
  typedef struct packed {
    logic [N_COM-1:0][2:0] com_level;
    logic [N_SEG-1:0][2:0] seg_level;
  } plcd_drive_t;
endpackage

/* File: dv/plcd_driver_bench.sv */
// Self-checking bench for the passive LCD driver sequencer.
// Assumes the panel model in plcd_panel_model.sv and a 250 MHz clock.
`timescale 1ns/100ps
module plcd_driver_bench;
  typedef struct packed {
    logic en;
    logic ext;
    logic [3:0] con;
    logic boost;
    logic [3:0] volt;
  } plcd_row_t;
  logic mclk, reset_n, deep_stop_state, ram_we, sof_clear, sof_irq_en;
  logic [3:0] ram_addr, panel_drive_voltage;
  logic [31:0] ram_wdata;
  logic sof_flag, sof_irq, boost_en, busy;
  logic [15:0] level_changes;
  plcd_pkg::plcd_cfg_t cfg;
  plcd_pkg::plcd_drive_t drive;
  int failures, total_checks, n;
  logic shown;
  logic [2:0] first_sel;
  plcd_row_t rows [5] = '{
    '{1'b1, 1'b0, 4'h5, 1'b1, 4'h5}, '{1'b1, 1'b1, 4'h9, 1'b0, 4'h0},
    '{1'b0, 1'b0, 4'hf, 1'b0, 4'hf}, '{1'b0, 1'b1, 4'h3, 1'b0, 4'h0},
    '{1'b1, 1'b0, 4'h0, 1'b1, 4'h0}};

  plcd_driver dut (.mclk(mclk), .reset_n(reset_n), .cfg(cfg),
    .deep_stop_state(deep_stop_state), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .sof_clear(sof_clear),
    .sof_irq_en(sof_irq_en), .drive(drive), .sof_flag(sof_flag),
    .sof_irq(sof_irq), .boost_en(boost_en),
    .panel_drive_voltage(panel_drive_voltage), .busy(busy));
  plcd_panel_model panel (.mclk(mclk), .reset_n(reset_n), .drive(drive),
    .level_changes(level_changes));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_vec(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wait_for(input logic want_flag, input logic want_busy);
    n = 0;
    while (!(sof_flag === want_flag && busy === want_busy) && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check_bit(n < 400, 1'b1);
  endtask

  // Waits until common 0 is the selected line of a driven phase
  task wait_sel0;
    n = 0;
    while (!(drive.com_level[0] inside {3'h0, 3'h3} &&
             drive.com_level[1] inside {3'h1, 3'h2}) && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check_bit(n < 400, 1'b1);
  endtask

  task finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    finish_test;
  end

  initial begin
    reset_n = 1'b0;
    deep_stop_state = 1'b0;
    ram_we = 1'b0;
    ram_addr = 4'h0;
    ram_wdata = 32'h0000_0000;
    sof_clear = 1'b0;
    sof_irq_en = 1'b0;
    cfg = '0;
    cfg.duty = plcd_pkg::PLCD_DUTY_1_4;
    cfg.bias = plcd_pkg::PLCD_BIAS_1_3;
    cfg.prescale = 16'h0003;
    cfg.dead_time = 4'h2;
    cfg.blink_mode = plcd_pkg::PLCD_BLINK_2;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    check_vec({sof_flag, sof_irq, boost_en, busy, panel_drive_voltage}, 0);
    foreach (rows[i]) begin
      @(posedge mclk);
      cfg.enable <= rows[i].en;
      cfg.ext_supply <= rows[i].ext;
      cfg.contrast <= rows[i].con;
      repeat (3) @(posedge mclk);
      #1;
      check_bit(boost_en, rows[i].boost);
      check_vec(panel_drive_voltage, rows[i].volt);
    end
    // Back-to-back pixel writes while frames run
    @(posedge mclk);
    ram_we <= 1'b1;
    ram_wdata <= 32'hffff_bfff;
    @(posedge mclk);
    ram_addr <= 4'hf;
    ram_wdata <= 32'ha5a5_5a5a;
    @(posedge mclk);
    ram_we <= 1'b0;
    wait_for(1'b1, 1'b1);
    check_bit(sof_irq, 1'b0);
    @(posedge mclk);
    sof_clear <= 1'b1;
    @(posedge mclk);
    sof_clear <= 1'b0;
    sof_irq_en <= 1'b1;
    #1;
    check_bit(sof_flag, 1'b0);
    wait_for(1'b1, 1'b1);
    #4;
    check_bit(sof_irq, 1'b1);
    // On pixels face the far rail of the selected common, off ones one step
    wait_sel0;
    first_sel = drive.com_level[0];
    shown = (drive.seg_level[0] == 3'h3 - first_sel);
    check_vec(drive.seg_level[15], 32'h3 - first_sel);
    check_vec(drive.seg_level[14], first_sel ? 32'h2 : 32'h1);
    repeat (24) @(posedge mclk);
    #1;
    wait_sel0;
    check_vec(drive.com_level[0], 32'h3 - first_sel);
    check_vec(drive.seg_level[15], first_sel);
    check_bit(drive.seg_level[0] == first_sel, !shown);
    @(posedge mclk);
    deep_stop_state <= 1'b1;
    cfg.phase_inv <= 1'b1;
    cfg.duty <= plcd_pkg::PLCD_DUTY_1_8;
    cfg.dead_time <= 4'h8;
    repeat (200) @(posedge mclk);
    #1;
    check_bit(busy, 1'b1);
    check_bit(level_changes > 16'h0008, 1'b1);
    @(posedge mclk);
    cfg.enable <= 1'b0;
    sof_clear <= 1'b1;
    sof_irq_en <= 1'b0;
    @(posedge mclk);
    sof_clear <= 1'b0;
    wait_for(1'b0, 1'b0);
    check_bit(boost_en, 1'b0);
    @(posedge mclk);
    cfg.enable <= 1'b1;
    repeat (60) @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check_vec({sof_flag, sof_irq, boost_en, busy, panel_drive_voltage}, 0);
    finish_test;
  end
endmodule

/* File: dv/plcd_panel_model.sv */
// Passive glass panel model: loads the terminals and counts drive changes.
// Assumes drive is registered on mclk and sampled on the rising edge.
`timescale 1ns/100ps
module plcd_panel_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire plcd_pkg::plcd_drive_t drive,
  output logic [15:0] level_changes
);
  plcd_pkg::plcd_drive_t last_q;

  // Polarity alternation and common scanning show as level changes
  always_ff @(posedge mclk) begin
    last_q <= drive;
    if (!reset_n) begin
      level_changes <= 16'h0000;
    end else if (drive !== last_q && level_changes != 16'hffff) begin
      level_changes <= level_changes + 16'h0001;
    end
  end
endmodule
